// File: design/sma_pkg.sv
// constants shared by the systolic stream block, its test port and its bench
package sma_pkg;
  // transfer kinds on the host stream
  localparam logic [1:0] SMA_MODE_WGT = 2'h0;
  localparam logic [1:0] SMA_MODE_DAT = 2'h1;
  localparam logic [1:0] SMA_MODE_RSV = 2'h2;
  localparam logic [1:0] SMA_MODE_RST = 2'h3;
  // stream geometry: 4 coordinates of 2 bytes, index 0..7
  localparam logic [2:0] SMA_IDX_RST = 3'h0;
  localparam logic [2:0] SMA_IDX_LAST = 3'h7;
  localparam int SMA_UNITS = 4;
  localparam int SMA_WORD_W = 16;
  // test port instruction set, 3-bit register
  localparam int SMA_IR_LEN = 3;
  localparam logic [2:0] SMA_IR_EXTEST = 3'h0;
  localparam logic [2:0] SMA_IR_IDCODE = 3'h1;
  localparam logic [2:0] SMA_IR_SAMPLE = 3'h2;
  localparam logic [2:0] SMA_IR_PROBE = 3'h3;
  localparam logic [2:0] SMA_IR_SCAN = 3'h4;
  localparam logic [2:0] SMA_IR_BYPASS = 3'h7;
  localparam logic [2:0] SMA_IR_CAPTURE = 3'h1;
  // identifier value is arbitrary, lsb must be one
  localparam logic [31:0] SMA_IDCODE = 32'h1357_9AC1;
  // probe register selector
  localparam logic [1:0] SMA_REG_WEIGHT = 2'h0;
  localparam logic [1:0] SMA_REG_MCAND = 2'h1;
  localparam logic [1:0] SMA_REG_SUMMAND = 2'h2;
  localparam logic [1:0] SMA_REG_PRODUCT = 2'h3;
  // data register widths and shift lengths
  localparam int SMA_SR_W = 256;
  localparam int SMA_BS_W = 20;
  localparam int SMA_BS_RES_LSB = 11;
  localparam int SMA_BS_RESV_BIT = 19;
  localparam logic [8:0] SMA_LEN_BYPASS = 9'h001;
  localparam logic [8:0] SMA_LEN_IR = 9'h003;
  localparam logic [8:0] SMA_LEN_IDCODE = 9'h020;
  localparam logic [8:0] SMA_LEN_PROBE = 9'h010;
  localparam logic [8:0] SMA_LEN_BS = 9'h014;
  localparam logic [8:0] SMA_LEN_SCAN = 9'h100;
endpackage : sma_pkg

// File: design/sma_mac.sv
// one multiply-accumulate cell of the 2x2 array
`timescale 1ns/100ps
module sma_mac (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // flow from the left and from above
  input wire logic en,
  input wire logic [15:0] a_in,
  input wire logic [15:0] s_in,
  input wire logic [15:0] w,
  // registered state; a, s and p also seen by the probe, c only by the scan
  output logic [15:0] a,
  output logic [15:0] s,
  output logic [15:0] p,
  output logic [15:0] c,
  output logic v
);
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] s;
    logic [15:0] p;
    logic [15:0] c;
    logic v;
  } sma_mac_st_t;

  sma_mac_st_t st;
  sma_mac_st_t next_st;
  logic [31:0] full;

  // wrap-around 16-bit arithmetic, no clamp stage
  always_comb begin
    full = a_in * w;
    next_st = st;
    next_st.v = en;
    if (en) begin
      next_st.a = a_in;
      next_st.s = s_in;
      next_st.p = full[15:0];
      next_st.c = 16'(full[15:0] + s_in);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign a = st.a;
  assign s = st.s;
  assign p = st.p;
  assign c = st.c;
  assign v = st.v;
endmodule : sma_mac

// File: design/sma_tap.sv
// test access port, run on the system clock with tck sampled as a plain input
`timescale 1ns/100ps
module sma_tap (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // views into the array
  output logic [3:0] probe_addr,
  input wire logic [15:0] probe_data,
  input wire logic [255:0] scan_data,
  input wire logic [19:0] pin_cap,
  output logic [19:0] bs_upd,
  output logic extest
);
  typedef enum logic [3:0] {
    SMA_TLR, SMA_RTI, SMA_SELDR, SMA_CAPDR, SMA_SHDR, SMA_EX1DR, SMA_PSDR, SMA_EX2DR,
    SMA_UPDR, SMA_SELIR, SMA_CAPIR, SMA_SHIR, SMA_EX1IR, SMA_PSIR, SMA_EX2IR, SMA_UPIR
  } sma_tap_state_t;

  typedef struct packed {
    sma_tap_state_t state;
    logic [2:0] ir;
    logic [255:0] sr;
    logic [3:0] addr;
    logic [19:0] bsu;
    logic tdo;
    logic tck_q;
  } sma_tap_st_t;

  localparam sma_tap_st_t TAP_RST = '{state: SMA_TLR, ir: sma_pkg::SMA_IR_IDCODE, sr: '0,
    addr: 4'h0, bsu: 20'h00000, tdo: 1'b0, tck_q: 1'b0};

  // standard sixteen-state walk
  function automatic sma_tap_state_t sma_walk(input sma_tap_state_t s, input logic m);
    case (s)
      SMA_TLR: sma_walk = m ? SMA_TLR : SMA_RTI;
      SMA_RTI: sma_walk = m ? SMA_SELDR : SMA_RTI;
      SMA_SELDR: sma_walk = m ? SMA_SELIR : SMA_CAPDR;
      SMA_CAPDR: sma_walk = m ? SMA_EX1DR : SMA_SHDR;
      SMA_SHDR: sma_walk = m ? SMA_EX1DR : SMA_SHDR;
      SMA_EX1DR: sma_walk = m ? SMA_UPDR : SMA_PSDR;
      SMA_PSDR: sma_walk = m ? SMA_EX2DR : SMA_PSDR;
      SMA_EX2DR: sma_walk = m ? SMA_UPDR : SMA_SHDR;
      SMA_UPDR: sma_walk = m ? SMA_SELDR : SMA_RTI;
      SMA_SELIR: sma_walk = m ? SMA_TLR : SMA_CAPIR;
      SMA_CAPIR: sma_walk = m ? SMA_EX1IR : SMA_SHIR;
      SMA_SHIR: sma_walk = m ? SMA_EX1IR : SMA_SHIR;
      SMA_EX1IR: sma_walk = m ? SMA_UPIR : SMA_PSIR;
      SMA_PSIR: sma_walk = m ? SMA_EX2IR : SMA_PSIR;
      SMA_EX2IR: sma_walk = m ? SMA_UPIR : SMA_SHIR;
      SMA_UPIR: sma_walk = m ? SMA_SELDR : SMA_RTI;
      default: sma_walk = SMA_TLR;
    endcase
  endfunction : sma_walk

  // selected data register length; unknown opcodes fall back to bypass
  function automatic logic [8:0] sma_len(input logic [2:0] ir);
    case (ir)
      sma_pkg::SMA_IR_IDCODE: sma_len = sma_pkg::SMA_LEN_IDCODE;
      sma_pkg::SMA_IR_PROBE: sma_len = sma_pkg::SMA_LEN_PROBE;
      sma_pkg::SMA_IR_SCAN: sma_len = sma_pkg::SMA_LEN_SCAN;
      sma_pkg::SMA_IR_EXTEST, sma_pkg::SMA_IR_SAMPLE: sma_len = sma_pkg::SMA_LEN_BS;
      default: sma_len = sma_pkg::SMA_LEN_BYPASS;
    endcase
  endfunction : sma_len

  // shift toward bit 0, tdi enters at the top of the selected length
  function automatic logic [255:0] sma_shift(input logic [255:0] v, input logic [8:0] len, input logic d);
    sma_shift = '0;
    for (int i = 0; i < 256; i++) begin
      if (9'(i) == len - 9'h001) begin
        sma_shift[i] = d;
      end else if (9'(i) < len - 9'h001) begin
        sma_shift[i] = v[i + 1];
      end
    end
  endfunction : sma_shift

  sma_tap_st_t st;
  sma_tap_st_t next_st;
  logic rise;
  logic fall;

  assign rise = tck & ~st.tck_q;
  assign fall = ~tck & st.tck_q;

  // actions of the current state happen on the tck rising edge
  always_comb begin
    next_st = st;
    next_st.tck_q = tck;
    if (rise) begin
      next_st.state = sma_walk(st.state, tms);
      case (st.state)
        SMA_TLR: next_st.ir = sma_pkg::SMA_IR_IDCODE;
        SMA_CAPIR: next_st.sr = {253'h0, sma_pkg::SMA_IR_CAPTURE};
        SMA_SHIR: next_st.sr = sma_shift(st.sr, sma_pkg::SMA_LEN_IR, tdi);
        SMA_UPIR: next_st.ir = st.sr[2:0];
        SMA_CAPDR: begin
          case (st.ir)
            sma_pkg::SMA_IR_IDCODE: next_st.sr = {224'h0, sma_pkg::SMA_IDCODE};
            sma_pkg::SMA_IR_PROBE: next_st.sr = {240'h0, probe_data};
            sma_pkg::SMA_IR_SCAN: next_st.sr = scan_data;
            sma_pkg::SMA_IR_EXTEST, sma_pkg::SMA_IR_SAMPLE: next_st.sr = {236'h0, pin_cap};
            default: next_st.sr = '0;
          endcase
        end
        SMA_SHDR: next_st.sr = sma_shift(st.sr, sma_len(st.ir), tdi);
        SMA_UPDR: begin
          if (st.ir == sma_pkg::SMA_IR_PROBE) begin
            next_st.addr = st.sr[3:0];
          end
          if (st.ir == sma_pkg::SMA_IR_EXTEST || st.ir == sma_pkg::SMA_IR_SAMPLE) begin
            next_st.bsu = st.sr[19:0];
          end
        end
        default: next_st.sr = st.sr;
      endcase
    end
    // tdo moves on the falling edge so the probe samples it stable
    if (fall && (st.state == SMA_SHDR || st.state == SMA_SHIR)) begin
      next_st.tdo = st.sr[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= TAP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign tdo = st.tdo;
  assign probe_addr = st.addr;
  assign bs_upd = st.bsu;
  assign extest = (st.ir == sma_pkg::SMA_IR_EXTEST);
endmodule : sma_tap

// File: design/sma_top.sv
// host byte stream, 2x2 multiply-accumulate array and result streamer
`timescale 1ns/100ps
// Contract
// - device keeps its own weight and data index
// - index reset: one valid cycle, byte ignored
// - kind 0x3 clears both indexes
// - eight kind 0x0 bytes load unit weights
// - weights persist across input matrices
// - eight kind 0x1 bytes carry input matrix
// - wide elements travel least significant byte first
// - idle gaps mid transfer simply pause indexing
// - result is eight gapless valid byte cycles
// - valid leads first byte, not back-to-back
// - input byte to result within eight cycles
// - input enters array at once on arrival
// - instruction register is three bits
// - opcodes and standard instruction behaviour
// - scan instruction chains array flops serially
// - probe address in one pass, data later
// - sixteen-bit probe, address bits 3:2 and 1:0
// - selector: weight, multiplicand, summand, product
// - cell adds input times weight to above
// - sums pass down, inputs pass right
module sma_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host input stream
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  input wire logic [1:0] in_kind,
  // result stream
  output logic [7:0] out_byte,
  output logic out_valid,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo
);
  typedef enum logic [1:0] {
    SMA_IDLE,
    SMA_LEAD,
    SMA_SEND
  } sma_out_state_t;

  typedef struct packed {
    logic [2:0] widx;
    logic [2:0] didx;
    logic [3:0][15:0] wt;
    logic [7:0] dlo;
    logic tag;
    logic [3:0][15:0] res;
    logic [3:0][15:0] shadow;
    logic pend;
    sma_out_state_t ost;
    logic [2:0] cnt;
    logic [7:0] obyte;
    logic ovalid;
  } sma_top_st_t;

  // byte i of a flattened four-word matrix, low byte of each word first
  function automatic logic [7:0] sma_pick(input logic [63:0] m, input logic [2:0] i);
    sma_pick = m[{i, 3'b000} +: 8];
  endfunction : sma_pick

  sma_top_st_t st;
  sma_top_st_t next_st;

  // array wiring, unit number is {row, column}
  logic [3:0] u_en;
  logic [3:0][15:0] u_ain;
  logic [3:0][15:0] u_sin;
  logic [3:0][15:0] u_a;
  logic [3:0][15:0] u_s;
  logic [3:0][15:0] u_p;
  logic [3:0][15:0] u_c;
  logic [3:0] u_v;

  logic [1:0] feed_en;
  logic [15:0] feed_val;
  logic take_dat;
  logic done;
  logic [3:0][15:0] src;

  // test port views
  logic [3:0] probe_addr;
  logic [15:0] probe_data;
  logic [255:0] scan_data;
  logic [19:0] pin_cap;
  logic [19:0] bs_upd;
  logic extest;

  // an input element enters its row on its high byte, no waiting for the rest
  assign take_dat = in_valid && (in_kind == sma_pkg::SMA_MODE_DAT);
  assign feed_val = {in_byte, st.dlo};
  assign feed_en[0] = take_dat && st.didx[0] && !st.didx[1];
  assign feed_en[1] = take_dat && st.didx[0] && st.didx[1];

  // a finished bottom-right cell on the second row closes the matrix
  assign done = u_v[3] && st.tag;

  // unit count as a constant function, declared ahead of the loop that uses it
  function automatic int sma_sma_units();
    sma_sma_units = sma_pkg::SMA_UNITS;
  endfunction : sma_sma_units

  genvar g;
  generate
    for (g = 0; g < sma_sma_units(); g++) begin : g_unit
      if (g % 2 == 0) begin : g_left
        assign u_ain[g] = feed_val;
        assign u_en[g] = feed_en[g / 2];
      end else begin : g_right
        assign u_ain[g] = u_a[g - 1];
        assign u_en[g] = u_v[g - 1];
      end
      if (g < 2) begin : g_top
        assign u_sin[g] = 16'h0000;
      end else begin : g_low
        assign u_sin[g] = u_c[g - 2];
      end
      sma_mac u_mac (
        .clk(clk),
        .rst(rst),
        .en(u_en[g]),
        .a_in(u_ain[g]),
        .s_in(u_sin[g]),
        .w(st.wt[g]),
        .a(u_a[g]),
        .s(u_s[g]),
        .p(u_p[g]),
        .c(u_c[g]),
        .v(u_v[g])
      );
    end
  endgenerate

  // result words as they stand this cycle, with the last one taken live
  always_comb begin
    src = st.res;
    if (done) begin
      src[3] = u_c[3];
    end
  end

  // host stream, index keeping and result streamer
  always_comb begin
    next_st = st;
    if (in_valid) begin
      case (in_kind)
        sma_pkg::SMA_MODE_RST: begin
          next_st.widx = sma_pkg::SMA_IDX_RST;
          next_st.didx = sma_pkg::SMA_IDX_RST;
        end
        sma_pkg::SMA_MODE_WGT: begin
          if (st.widx[0]) begin
            next_st.wt[st.widx[2:1]][15:8] = in_byte;
          end else begin
            next_st.wt[st.widx[2:1]][7:0] = in_byte;
          end
          next_st.widx = st.widx + 3'h1;
        end
        sma_pkg::SMA_MODE_DAT: begin
          if (!st.didx[0]) begin
            next_st.dlo = in_byte;
          end
          next_st.didx = st.didx + 3'h1;
        end
        default: next_st.didx = st.didx; // reserved kind is ignored
      endcase
    end
    // without valid nothing moves, so gaps just pause both indexes
    if (feed_en[1]) begin
      next_st.tag = st.didx[2];
    end
    // capture column results of the bottom row
    if (u_v[2]) begin
      next_st.res[{st.tag, 1'b0}] = u_c[2];
    end
    if (u_v[3]) begin
      next_st.res[{st.tag, 1'b1}] = u_c[3];
    end
    case (st.ost)
      SMA_IDLE: begin
        if (done) begin
          next_st.shadow = src;
          next_st.ost = SMA_LEAD;
          next_st.ovalid = 1'b1;
        end
      end
      SMA_LEAD: begin
        next_st.ost = SMA_SEND;
        next_st.cnt = sma_pkg::SMA_IDX_RST;
        next_st.obyte = sma_pick(st.shadow, sma_pkg::SMA_IDX_RST);
      end
      SMA_SEND: begin
        if (done) begin
          next_st.pend = 1'b1;
        end
        if (st.cnt == sma_pkg::SMA_IDX_LAST) begin
          if (st.pend || done) begin
            // back-to-back stream continues with no lead cycle
            next_st.shadow = src;
            next_st.pend = 1'b0;
            next_st.cnt = sma_pkg::SMA_IDX_RST;
            next_st.obyte = sma_pick(src, sma_pkg::SMA_IDX_RST);
          end else begin
            next_st.ost = SMA_IDLE;
            next_st.ovalid = 1'b0;
          end
        end else begin
          next_st.cnt = st.cnt + 3'h1;
          next_st.obyte = sma_pick(st.shadow, st.cnt + 3'h1);
        end
      end
      default: begin
        next_st.ost = SMA_IDLE;
        next_st.ovalid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // probe mux; no crossing logic, the host keeps the array still meanwhile
  always_comb begin
    case (probe_addr[1:0])
      sma_pkg::SMA_REG_WEIGHT: probe_data = st.wt[probe_addr[3:2]];
      sma_pkg::SMA_REG_MCAND: probe_data = u_a[probe_addr[3:2]];
      sma_pkg::SMA_REG_SUMMAND: probe_data = u_s[probe_addr[3:2]];
      sma_pkg::SMA_REG_PRODUCT: probe_data = u_p[probe_addr[3:2]];
      default: probe_data = 16'h0000;
    endcase
  end

  // the scan view covers every data flop of the four cells
  assign scan_data = {u_c, u_p, u_s, u_a};

  // boundary cells: inputs low, then result pins
  assign pin_cap = {out_valid, out_byte, in_kind, in_valid, in_byte};

  sma_tap u_tap (
    .clk(clk),
    .rst(rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .probe_addr(probe_addr),
    .probe_data(probe_data),
    .scan_data(scan_data),
    .pin_cap(pin_cap),
    .bs_upd(bs_upd),
    .extest(extest)
  );

  // extest hands the result pins to the boundary register
  assign out_byte = extest ? bs_upd[sma_pkg::SMA_BS_RES_LSB +: 8] : st.obyte;
  assign out_valid = extest ? bs_upd[sma_pkg::SMA_BS_RESV_BIT] : st.ovalid;
endmodule : sma_top

// File: bench/sma_probe.sv
// test port probe model: clocks the port at its 2 MHz rate, only inside frames
`timescale 1ns/100ps
module sma_probe (
  // test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // clock parks low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 500 ns test clock period; tdo is taken just before the rise
  task tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #250;
    o = tdo;
    tck = 1'b1;
    #250;
    tck = 1'b0;
  endtask : tick
  // five high tms beats reach test-logic-reset from any state, then idle
  task tap_reset;
    logic o;
    repeat (5) tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
  endtask : tap_reset
  // walk from idle through a shift state, lsb first, back to idle
  task shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    tick(1'b1, tdi, o);
    if (ir) tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
    tick(1'b0, tdi, o);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, din[k], o);
      dout[k] = o;
    end
    // released data line flips on each of the two exit beats, ending back on the last data bit
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask : shift
endmodule : sma_probe

// File: bench/sma_top_sva.sv
// port assertions for the systolic stream block
`timescale 1ns/100ps
module sma_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host input stream
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  input wire logic [1:0] in_kind,
  // result stream
  input wire logic [7:0] out_byte,
  input wire logic out_valid,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] didx;
  logic [4:0] vcnt;
  logic last_dat;
  // last byte of an input matrix as the host sees it
  assign last_dat = in_valid && in_kind == sma_pkg::SMA_MODE_DAT && didx == sma_pkg::SMA_IDX_LAST;
  // mirror of the data index and length of the current valid run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      didx <= 3'h0;
      vcnt <= 5'h00;
    end else begin
      vcnt <= out_valid ? vcnt + 5'h01 : 5'h00;
      if (in_valid && in_kind == sma_pkg::SMA_MODE_RST) didx <= 3'h0;
      else if (in_valid && in_kind == sma_pkg::SMA_MODE_DAT) didx <= didx + 3'h1;
    end
  end
  lead_cycle_a: assert property (last_dat && !out_valid |=> !out_valid ##1 !out_valid ##1 out_valid)
    else $error("result lead cycle misplaced");
  burst_len_a: assert property ($rose(out_valid) |=> out_valid [*8])
    else $error("result stream has a gap");
  stream_end_a: assert property ($fell(out_valid) |-> vcnt[2:0] == 3'h1)
    else $error("result stream length wrong");
  start_cause_a: assert property ($rose(out_valid) |-> $past(last_dat, 3))
    else $error("result stream without a full matrix");
  latency_bound_a: assert property (last_dat |-> ##[1:8] (out_valid && $past(out_valid)))
    else $error("result too late");
  idle_hold_a: assert property (!out_valid |-> $stable(out_byte))
    else $error("result byte moves while idle");
  b2b_join_a: assert property (last_dat && $past(last_dat, 8) |=> out_valid [*8])
    else $error("back to back streams not joined");
  reset_clear_a: assert property ($fell(rst) |-> !out_valid && out_byte == 8'h00 && tdo == 1'b0)
    else $error("outputs not cleared by reset");
  // main scenarios reached
  cover property ($rose(out_valid));
  cover property (last_dat && $past(last_dat, 8));
  cover property (in_valid && in_kind == sma_pkg::SMA_MODE_RSV);
  cover property ($changed(tdo));
endmodule : sma_top_sva
bind sma_top sma_top_sva chk (
  .clk(clk), .rst(rst), .in_byte(in_byte), .in_valid(in_valid), .in_kind(in_kind),
  .out_byte(out_byte), .out_valid(out_valid), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo)
);

// File: bench/sma_top_test.sv
// self-checking bench for the systolic stream block and its test port
`timescale 1ns/100ps
module sma_top_test;
  // one row: load flag, weights, inputs, expected result; element e at bits 16e
  typedef struct packed {
    logic ld;
    logic [63:0] w;
    logic [63:0] d;
    logic [63:0] r;
  } sma_row_t;
  sma_row_t rows [3];
  logic clk;
  logic rst;
  logic [7:0] in_byte;
  logic in_valid;
  logic [1:0] in_kind;
  logic [7:0] out_byte;
  logic out_valid;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic prev_v;
  logic [7:0] rq [$];
  logic [31:0] got;
  int err_total;
  int cmp_count;
  int leads;
  sma_top dut (.clk(clk), .rst(rst), .in_byte(in_byte), .in_valid(in_valid), .in_kind(in_kind),
    .out_byte(out_byte), .out_valid(out_valid), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  sma_probe probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // 100 ns system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // gather result bytes; the lead cycle of a stream carries none
  always @(posedge clk) begin
    if (out_valid === 1'b1 && prev_v === 1'b1) rq.push_back(out_byte);
    if (out_valid === 1'b1 && prev_v !== 1'b1) leads++;
    prev_v <= out_valid;
  end
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one transfer, driven just after the edge
  task xfer(input logic [1:0] kind, input logic [7:0] b);
    @(posedge clk);
    #10;
    in_valid = 1'b1;
    in_kind = kind;
    in_byte = b;
  endtask : xfer
  task idle;
    @(posedge clk);
    #10;
    in_valid = 1'b0;
    in_byte = ~in_byte;
  endtask : idle
  // eight bytes lsb first, one idle cycle before byte gap (none when gap is 8)
  task send(input logic [1:0] kind, input logic [63:0] v, input int gap);
    for (int k = 0; k < 8; k++) begin
      if (k == gap) idle();
      xfer(kind, v[8*k +: 8]);
    end
  endtask : send
  // bounded wait for eight bytes, compared as four little-endian words
  task expect_res(input logic [63:0] r);
    logic [15:0] wd;
    for (int t = 0; t < 60 && rq.size() < 8; t++) @(posedge clk);
    if (rq.size() < 8) begin
      err_total++;
      $display("Error result bytes expected 8 seen %0d", rq.size());
      test_done();
    end
    for (int e = 0; e < 4; e++) begin
      wd[7:0] = rq.pop_front();
      wd[15:8] = rq.pop_front();
      check("result word", {16'h0000, r[16*e +: 16]}, {16'h0000, wd});
    end
  endtask : expect_res
  initial begin
    rows[0] = {1'b1, 64'h0003_0002_0001_0000, 64'h0007_0006_0005_0004, 64'h001B_000E_0013_000A};
    rows[1] = {1'b0, 64'h0000_0000_0000_0000, 64'h0003_0100_0001_0102, 64'h0109_0006_0105_0002};
    rows[2] = {1'b1, 64'h0010_0002_FFFF_0100, 64'h8000_0003_0002_0001, 64'hFFFD_0300_001F_0104};
    rst = 1'b1;
    in_byte = 8'h00;
    in_valid = 1'b0;
    in_kind = 2'h0;
    prev_v = 1'b0;
    err_total = 0;
    cmp_count = 0;
    leads = 0;
    repeat (12) @(posedge clk);
    #10;
    rst = 1'b0;
    check("idle outputs", 32'h0, {22'h0, out_valid, tdo, out_byte});
    // host order: index reset, weights, data, results
    xfer(sma_pkg::SMA_MODE_RST, 8'hA5);
    for (int n = 0; n < 3; n++) begin
      if (rows[n].ld) send(sma_pkg::SMA_MODE_WGT, rows[n].w, 8);
      send(sma_pkg::SMA_MODE_DAT, rows[n].d, 8);
      idle();
      expect_res(rows[n].r);
    end
    // reserved kind and a mid-matrix gap leave the index alone
    xfer(sma_pkg::SMA_MODE_RSV, 8'hFF);
    send(sma_pkg::SMA_MODE_DAT, rows[2].d, 3);
    idle();
    expect_res(rows[2].r);
    // partial weights and data dropped by one index reset
    repeat (2) xfer(sma_pkg::SMA_MODE_DAT, 8'h77);
    repeat (3) xfer(sma_pkg::SMA_MODE_WGT, 8'hEE);
    xfer(sma_pkg::SMA_MODE_RST, 8'h11);
    send(sma_pkg::SMA_MODE_WGT, rows[0].w, 4);
    send(sma_pkg::SMA_MODE_DAT, rows[0].d, 8);
    idle();
    expect_res(rows[0].r);
    // two matrices back to back: one lead, sixteen gapless bytes
    leads = 0;
    send(sma_pkg::SMA_MODE_DAT, rows[0].d, 8);
    send(sma_pkg::SMA_MODE_DAT, rows[1].d, 8);
    idle();
    expect_res(rows[0].r);
    expect_res(rows[1].r);
    check("stream leads", 32'h1, leads);
    // test port with the array halted
    probe.tap_reset();
    probe.shift(1'b0, 32, 32'h0, got);
    check("identifier", sma_pkg::SMA_IDCODE, got);
    probe.shift(1'b1, 3, {29'h0, sma_pkg::SMA_IR_BYPASS}, got);
    check("instruction capture", {29'h0, sma_pkg::SMA_IR_CAPTURE}, got);
    probe.shift(1'b0, 2, 32'h3, got);
    check("bypass", 32'h2, got);
    probe.shift(1'b1, 3, {29'h0, sma_pkg::SMA_IR_PROBE}, got);
    for (int u = 0; u < 4; u++) begin
      probe.shift(1'b0, 16, {28'h0, u[1:0], sma_pkg::SMA_REG_WEIGHT}, got);
      probe.shift(1'b0, 16, 32'h0, got);
      check("probed weight", {16'h0000, rows[0].w[16*u +: 16]}, got);
    end
    test_done();
  end
endmodule : sma_top_test
